// ---- sevq_guest.sv ----
// Guest driver model: stocks the event queue with record-sized buffers
`timescale 1ns/10ps
`default_nettype none
module sevq_guest
    import sevq_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        add,
    input  wire logic        buf_take,
    output logic             buf_avail,
    output logic [31:0]      buf_len,
    output logic             buf_writable
);
    int cnt;
    // Buffers are posted one at a time by the bench and used by the device
    always @(posedge sys_clk) begin
        if (rst)
            cnt <= 0;
        else
            cnt <= cnt + int'(add) - int'(buf_take);
    end
    // Empty queue shows no valid length, so a stale value is never trusted
    assign buf_avail    = (cnt != 0);
    assign buf_len      = (cnt != 0) ? REC_BYTES : ~REC_BYTES;
    assign buf_writable = (cnt != 0);
endmodule
`default_nettype wire

// ---- sevq_pkg.sv ----
// Constants, register map and types of the SCSI event queue block
// Notes on behaviour
// - Record: 32-bit code, 8-byte unit address, 32-bit reason, little-endian.
// - Transport reset is code 1; reasons 0 hard, 1 appeared, 2 removed.
// - Dropped events set code top bit; no-event code may report the loss.
// - No removal or appeared reason unless hot-plug was negotiated.
// - Never raise parameter-change event for multimedia-type units.
// - Legacy interface writes record fields in guest native byte order.
// - Feature 28 allows indirect descriptor tables.
// - Feature 29 enables used and available event index fields.
// - Device always offers feature 32; may halt if not accepted.
// - With feature 24, interrupt when a queue runs dry despite suppression; code raises it only in legacy mode.
// - Transitional device offers feature 27; driver accepts it.
// - Feature 30 is reserved and never negotiated.
package sevq_pkg;
    // ****************************************************************
    // Event record layout
    // ****************************************************************
    localparam logic [31:0] EVT_NO_EVENT        = 32'h0000_0000;
    localparam logic [31:0] EVT_TRANSPORT_RESET = 32'h0000_0001;
    localparam logic [31:0] EVT_ASYNC_NOTIFY    = 32'h0000_0002;
    localparam logic [31:0] param_change_event_code = 32'h0000_0003;
    localparam int          EVT_MISSED_BIT      = 31;
    localparam logic [31:0] reason_unit_hard    = 32'h0000_0000;
    localparam logic [31:0] reason_unit_appeared = 32'h0000_0001;
    localparam logic [31:0] reason_unit_removed = 32'h0000_0002;
    localparam logic [7:0]  UNIT_TYPE_MMC       = 8'h05;
    localparam int          REC_WORDS           = 5;
    localparam logic [31:0] REC_BYTES           = 32'h0000_0014;
    // ****************************************************************
    // Feature bits
    // ****************************************************************
    localparam int FEAT_HOTPLUG  = 1;
    localparam int FEAT_DRAINED  = 24;
    localparam int FEAT_ANY_LAY  = 27;
    localparam int FEAT_INDIRECT = 28;
    localparam int FEAT_EVT_IDX  = 29;
    localparam int FEAT_RSVD30   = 30;
    localparam int FEAT_VERSION1 = 32;
    localparam logic [63:0] FEAT_FIXED_OFFER = 64'h0000_0001_0800_0000;
    localparam logic [63:0] FEAT_OPT_MASK    = 64'h0000_0000_3100_0002;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_OFFER_LO  = 8'h04;
    localparam logic [7:0] REG_OFFER_HI  = 8'h08;
    localparam logic [7:0] REG_ACCEPT_LO = 8'h0c;
    localparam logic [7:0] REG_ACCEPT_HI = 8'h10;
    localparam logic [7:0] REG_ACTIVE_LO = 8'h14;
    localparam logic [7:0] REG_ACTIVE_HI = 8'h18;
    localparam logic [7:0] REG_STATUS    = 8'h1c;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h20;
    localparam logic [7:0] REG_IRQ_EN    = 8'h24;
    localparam logic [7:0] REG_IRQ_CLR   = 8'h28;
    localparam logic [7:0] REG_DROPS     = 8'h2c;
    localparam int CTRL_LEGACY = 0;
    localparam int CTRL_BE     = 1;
    localparam int CTRL_OPTIN  = 2;
    localparam int IRQ_WRITTEN = 0;
    localparam int IRQ_DROPPED = 1;
    localparam int IRQ_DRAINED = 2;
    localparam int IRQ_FILTER  = 3;
    localparam int IRQ_BADVER  = 4;
    localparam int IRQ_BITS    = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        SEVQ_IDLE  = 2'b00,
        SEVQ_WRITE = 2'b01,
        SEVQ_DONE  = 2'b10
    } sevq_state_e;
endpackage

// ---- sevq_rec_mem.sv ----
// Record staging memory: holds the words of one event record
`timescale 1ns/10ps
`default_nettype none
module sevq_rec_mem
    import sevq_pkg::*;
#(
    parameter int WORDS = REC_WORDS
) (
    input  wire logic                     sys_clk,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(WORDS)-1:0] wr_addr,
    input  wire logic [31:0]              wr_data,
    input  wire logic [$clog2(WORDS)-1:0] rd_addr,
    output logic      [31:0]              rd_data
);
    logic [31:0] mem [WORDS];
    initial begin
        if (WORDS < 2) begin
            $error("sevq_rec_mem: WORDS must be at least 2");
        end
    end
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    always_ff @(posedge sys_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ---- sevq_top.sv ----
// Event queue writer and feature negotiation of a virtual SCSI host
`timescale 1ns/10ps
`default_nettype none
module sevq_top
    import sevq_pkg::*;
#(
    parameter int DROP_W = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Event source
    input  wire logic        evt_valid,
    input  wire logic [31:0] evt_code,
    input  wire logic [63:0] evt_lun,
    input  wire logic [31:0] evt_reason,
    input  wire logic [7:0]  evt_unit_type,
    output logic             evt_ready,
    // Buffer supply from the queue engine
    input  wire logic        buf_avail,
    input  wire logic [31:0] buf_len,
    input  wire logic        buf_writable,
    output logic             buf_take,
    // Record word output, one word a cycle
    output logic             rec_valid,
    output logic [2:0]       rec_index,
    output logic [31:0]      rec_word,
    output logic             rec_last,
    output logic             irq
);
    initial begin
        if (DROP_W < 1 || DROP_W > 32) begin
            $error("sevq_top: DROP_W must be 1 to 32");
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0]         ctrl;
    logic [63:0]         drv_accept;
    logic [63:0]         active;
    logic [IRQ_BITS-1:0] irq_stat;
    logic [IRQ_BITS-1:0] irq_en;
    logic [DROP_W-1:0]   drops;
    logic                lost;
    logic                halted;
    sevq_state_e         state;
    logic [2:0]          widx;
    logic [2:0]          ridx;
    logic [31:0]         mem_rd;

    logic [63:0] offer;
    logic [63:0] next_active;
    logic        legacy;
    logic        big_end;
    assign legacy  = ctrl[CTRL_LEGACY];
    assign big_end = legacy & ctrl[CTRL_BE];
    // Optional bits appear only where software opted in; bit 30 never does
    always_comb begin
        offer = FEAT_FIXED_OFFER;
        if (ctrl[CTRL_OPTIN]) begin
            offer = offer | FEAT_OPT_MASK;
        end
        offer[FEAT_RSVD30] = 1'b0;
        next_active = offer & drv_accept;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl       <= CTRL_RESET;
            drv_accept <= '0;
            irq_en     <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL:      ctrl <= reg_wdata;
                REG_ACCEPT_LO: drv_accept[31:0] <= reg_wdata;
                REG_ACCEPT_HI: drv_accept[63:32] <= reg_wdata;
                REG_IRQ_EN:    irq_en <= reg_wdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // Negotiated set: accepted bits that were offered
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active <= '0;
        end else begin
            active <= next_active;
        end
    end

    // Outside legacy mode, device refuses to deliver events until version 1 is accepted
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            halted <= 1'b0;
        end else begin
            halted <= ~legacy & ~active[FEAT_VERSION1];
        end
    end

    // ****************************************************************
    // Event acceptance and filtering
    // ****************************************************************
    logic evt_take;
    logic filtered;
    logic buf_ok;
    logic drop_now;
    logic hot_reason;
    assign hot_reason = (evt_code == EVT_TRANSPORT_RESET) &&
                        (evt_reason == reason_unit_appeared ||
                         evt_reason == reason_unit_removed);
    assign filtered = (hot_reason && !active[FEAT_HOTPLUG]) ||
                      (evt_code == param_change_event_code &&
                       evt_unit_type == UNIT_TYPE_MMC);
    assign buf_ok   = buf_avail && buf_writable && buf_len >= REC_BYTES;
    assign evt_take = (state == SEVQ_IDLE) && evt_valid && !halted;
    assign drop_now = evt_take && !filtered && !buf_ok;
    // A waiting loss is reported on its own once a buffer appears while no event is offered
    logic loss_only;
    assign loss_only = (state == SEVQ_IDLE) && !evt_valid && lost &&
                       buf_ok && !halted;
    logic start;
    assign start = (evt_take && !filtered && buf_ok) || loss_only;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evt_ready <= 1'b0;
        end else begin
            evt_ready <= (state == SEVQ_IDLE) && !halted && !evt_take;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            buf_take <= 1'b0;
        end else begin
            buf_take <= start;
        end
    end

    // ****************************************************************
    // Record staging
    // ****************************************************************
    function automatic logic [31:0] order(input logic [31:0] w,
                                          input logic be);
        order = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction

    logic [31:0] code_out;
    logic        stage_we;
    logic [31:0] stage_d;
    logic [31:0] rec_src [REC_WORDS];
    always_comb begin
        code_out = loss_only ? EVT_NO_EVENT : evt_code;
        code_out[EVT_MISSED_BIT] = lost | drop_now;
    end

    // Words: code, unit address low and high words, reason
    always_comb begin
        stage_we = 1'b0;
        stage_d  = '0;
        if (state == SEVQ_WRITE && widx < 3'(REC_WORDS)) begin
            stage_we = 1'b1;
            stage_d  = rec_src[widx];
        end
    end

    logic [31:0] hold_code;
    logic [63:0] hold_lun;
    logic [31:0] hold_reason;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_code   <= '0;
            hold_lun    <= '0;
            hold_reason <= '0;
        end else if (start) begin
            hold_code   <= code_out;
            hold_lun    <= loss_only ? 64'h0 : evt_lun;
            hold_reason <= loss_only ? 32'h0 : evt_reason;
        end
    end
    // Unit address is a byte array, so its lane order never swaps
    assign rec_src[0] = order(hold_code, big_end);
    assign rec_src[1] = hold_lun[31:0];
    assign rec_src[2] = hold_lun[63:32];
    assign rec_src[3] = order(hold_reason, big_end);
    assign rec_src[4] = 32'h0;

    sevq_rec_mem #(
        .WORDS (REC_WORDS)
    ) u_mem (
        .sys_clk (sys_clk),
        .wr_en   (stage_we),
        .wr_addr (widx),
        .wr_data (stage_d),
        .rd_addr (ridx),
        .rd_data (mem_rd)
    );

    // ****************************************************************
    // Sequencer: stage four words, then stream them out
    // ****************************************************************
    localparam logic [2:0] LAST_IDX = 3'h3;
    logic rd_pend;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= SEVQ_IDLE;
            widx  <= '0;
            ridx  <= '0;
        end else begin
            case (state)
                SEVQ_IDLE: begin
                    widx <= '0;
                    ridx <= '0;
                    if (start) begin
                        state <= SEVQ_WRITE;
                    end
                end
                SEVQ_WRITE: begin
                    if (widx == LAST_IDX) begin
                        state <= SEVQ_DONE;
                    end
                    widx <= widx + 3'h1;
                end
                SEVQ_DONE: begin
                    if (ridx == LAST_IDX) begin
                        state <= SEVQ_IDLE;
                    end
                    ridx <= ridx + 3'h1;
                end
                default: state <= SEVQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_pend   <= 1'b0;
            rec_valid <= 1'b0;
            rec_index <= '0;
            rec_last  <= 1'b0;
        end else begin
            rd_pend   <= (state == SEVQ_DONE);
            rec_valid <= rd_pend;
            rec_index <= ridx - 3'h1;
            rec_last  <= rd_pend && (ridx == 3'h4);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rec_word <= '0;
        end else begin
            rec_word <= mem_rd;
        end
    end

    logic rec_done;
    assign rec_done = rec_valid && rec_last;

    // ****************************************************************
    // Lost-event flag and drop counter
    // ****************************************************************
    // Supply is judged one cycle after a take, once the queue has settled
    logic took;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            took <= 1'b0;
        end else begin
            took <= buf_take;
        end
    end
    // A new drop wins over the clear from a starting loss record
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lost <= 1'b0;
        end else if (drop_now) begin
            lost <= 1'b1;
        end else if (start && code_out[EVT_MISSED_BIT]) begin
            lost <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drops <= '0;
        end else if (drop_now && drops != '1) begin
            drops <= drops + 1'b1;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [IRQ_BITS-1:0] irq_set;
    logic                drained;
    assign drained = active[FEAT_DRAINED] && legacy && took &&
                     !buf_avail;
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_WRITTEN] = rec_done;
        irq_set[IRQ_DROPPED] = drop_now;
        irq_set[IRQ_DRAINED] = drained;
        irq_set[IRQ_FILTER]  = evt_take && filtered;
        irq_set[IRQ_BADVER]  = halted && evt_valid;
    end
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_BITS; gi++) begin : g_irq
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    irq_stat[gi] <= 1'b0;
                end else if (irq_set[gi]) begin
                    irq_stat[gi] <= 1'b1;
                end else if (reg_wr && reg_addr == REG_IRQ_CLR &&
                             reg_wdata[gi]) begin
                    irq_stat[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    // Drained-queue interrupt ignores the enable mask, as suppression may not
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_en) || irq_stat[IRQ_DRAINED];
        end
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:      reg_rdata <= ctrl;
                REG_OFFER_LO:  reg_rdata <= offer[31:0];
                REG_OFFER_HI:  reg_rdata <= offer[63:32];
                REG_ACCEPT_LO: reg_rdata <= drv_accept[31:0];
                REG_ACCEPT_HI: reg_rdata <= drv_accept[63:32];
                REG_ACTIVE_LO: reg_rdata <= active[31:0];
                REG_ACTIVE_HI: reg_rdata <= active[63:32];
                REG_STATUS:    reg_rdata <= {29'h0, halted, lost,
                                             state != SEVQ_IDLE};
                REG_IRQ_STAT:  reg_rdata <= 32'(irq_stat);
                REG_IRQ_EN:    reg_rdata <= 32'(irq_en);
                REG_DROPS:     reg_rdata <= 32'(drops);
                default:       reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_drop_sets_lost;
        @(posedge sys_clk) disable iff (rst) drop_now |=> lost;
    endproperty
    a_drop_sets_lost: assert property (p_drop_sets_lost)
        else $error("drop did not set lost flag");
    property p_missed_bit;
        @(posedge sys_clk) disable iff (rst)
            (start && lost && !big_end) |=> hold_code[EVT_MISSED_BIT];
    endproperty
    a_missed_bit: assert property (p_missed_bit)
        else $error("loss not flagged in record");
    property p_no_hot;
        @(posedge sys_clk) disable iff (rst)
            (evt_take && hot_reason && !active[FEAT_HOTPLUG]) |-> !start;
    endproperty
    a_no_hot: assert property (p_no_hot)
        else $error("hot-plug reason sent without feature");
    property p_no_mmc;
        @(posedge sys_clk) disable iff (rst)
            (evt_take && evt_unit_type == UNIT_TYPE_MMC &&
             evt_code == param_change_event_code) |-> !start;
    endproperty
    a_no_mmc: assert property (p_no_mmc)
        else $error("parameter change sent for multimedia unit");
    property p_ver_offered;
        @(posedge sys_clk) disable iff (rst) offer[FEAT_VERSION1];
    endproperty
    a_ver_offered: assert property (p_ver_offered)
        else $error("version feature not offered");
    property p_anylay;
        @(posedge sys_clk) disable iff (rst)
            offer[FEAT_ANY_LAY] && !offer[FEAT_RSVD30];
    endproperty
    a_anylay: assert property (p_anylay)
        else $error("bad fixed offer bits");
    property p_rec_len;
        @(posedge sys_clk) disable iff (rst)
            start |-> ##[8:12] rec_done;
    endproperty
    a_rec_len: assert property (p_rec_len)
        else $error("record not completed in time");
    property p_code_first;
        @(posedge sys_clk) disable iff (rst)
            (rec_valid && rec_index == 3'h0 && !big_end) |->
            rec_word == hold_code;
    endproperty
    a_code_first: assert property (p_code_first)
        else $error("event code not first word");
    c_record: cover property (@(posedge sys_clk) rec_done);
    c_drop: cover property (@(posedge sys_clk) drop_now);
    c_loss_only: cover property (@(posedge sys_clk) loss_only);
    c_drained: cover property (@(posedge sys_clk) drained);
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench of the SCSI event queue block
`timescale 1ns/10ps
`default_nettype none
module testbench
    import sevq_pkg::*;
;
    logic        sys_clk = 1'b0, rst = 1'b1, add = 1'b0;
    logic [7:0]  reg_addr = 8'h00, evt_unit_type = 8'h00;
    logic [31:0] reg_wdata = 32'h0, evt_code = 32'h0, evt_reason = 32'h0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, evt_valid = 1'b0;
    logic [63:0] evt_lun = 64'h0;
    logic [31:0] reg_rdata, buf_len, rec_word, d;
    logic        evt_ready, buf_avail, buf_writable, buf_take;
    logic        rec_valid, rec_last, irq;
    logic [2:0]  rec_index;
    logic [31:0] got [4];
    int          fail_count = 0, n_compared = 0, n_rec = 0;

    always #4 sys_clk = ~sys_clk;

    sevq_top uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .evt_valid(evt_valid), .evt_code(evt_code),
        .evt_lun(evt_lun), .evt_reason(evt_reason),
        .evt_unit_type(evt_unit_type), .evt_ready(evt_ready),
        .buf_avail(buf_avail), .buf_len(buf_len),
        .buf_writable(buf_writable), .buf_take(buf_take),
        .rec_valid(rec_valid), .rec_index(rec_index), .rec_word(rec_word),
        .rec_last(rec_last), .irq(irq));
    sevq_guest guest (.sys_clk(sys_clk), .rst(rst), .add(add),
        .buf_take(buf_take), .buf_avail(buf_avail), .buf_len(buf_len),
        .buf_writable(buf_writable));

    // ****************************************************************
    // Record capture and shared tasks
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (rec_valid && rec_index < 3'h4) begin
            got[rec_index[1:0]] <= rec_word;
            if (rec_last)
                n_rec <= n_rec + 1;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic post_buf();
        @(posedge sys_clk);
        add <= 1'b1;
        @(posedge sys_clk);
        add <= 1'b0;
    endtask

    task automatic ev(input logic [31:0] c, input logic [31:0] r,
                      input logic [7:0] ty);
        @(posedge sys_clk);
        evt_valid     <= 1'b1;
        evt_code      <= c;
        evt_reason    <= r;
        evt_unit_type <= ty;
        evt_lun       <= 64'h0807_0605_0403_0201;
        @(posedge sys_clk);
        evt_valid     <= 1'b0;
        repeat (16) @(posedge sys_clk);
    endtask

    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_features();
        ev(EVT_TRANSPORT_RESET, reason_unit_hard, 8'h00);
        chk({31'h0, evt_ready}, 32'h0);
        rd(REG_IRQ_STAT);
        chk(d, 32'h0000_0010);
        rd(REG_OFFER_LO);
        chk(d & 32'h4800_0000, 32'h0800_0000);
        rd(REG_OFFER_HI);
        chk(d, 32'h0000_0001);
        wr(REG_CTRL, 32'h0000_0004);
        wr(REG_ACCEPT_LO, 32'h4800_0002);
        wr(REG_ACCEPT_HI, 32'h0000_0001);
        rd(REG_ACTIVE_LO);
        chk(d, 32'h0800_0002);
        rd(REG_STATUS);
        chk(d, 32'h0000_0000);
        chk({31'h0, evt_ready}, 32'h1);
    endtask

    task automatic t_record();
        wr(REG_IRQ_EN, 32'h0000_0001);
        post_buf();
        ev(EVT_TRANSPORT_RESET, reason_unit_appeared, 8'h00);
        chk(got[0], 32'h0000_0001);
        chk(got[1], 32'h0403_0201);
        chk(got[2], 32'h0807_0605);
        chk(got[3], 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
        wr(REG_IRQ_CLR, 32'h0000_0001);
        wr(REG_IRQ_EN, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0);
    endtask

    // No buffer: event lost, then a loss-only record once one appears
    task automatic t_lost();
        ev(EVT_TRANSPORT_RESET, reason_unit_hard, 8'h00);
        rd(REG_STATUS);
        chk(d, 32'h0000_0002);
        rd(REG_DROPS);
        chk(d, 32'h0000_0001);
        post_buf();
        repeat (16) @(posedge sys_clk);
        chk(got[0], 32'h8000_0000);
        rd(REG_STATUS);
        chk(d, 32'h0000_0000);
    endtask

    task automatic t_filter();
        wr(REG_ACCEPT_LO, 32'h0800_0000);
        post_buf();
        ev(EVT_TRANSPORT_RESET, reason_unit_removed, 8'h00);
        ev(param_change_event_code, 32'h0000_092a, UNIT_TYPE_MMC);
        chk(n_rec, 32'h2);
        rd(REG_IRQ_STAT);
        chk(d & 32'h8, 32'h8);
        ev(param_change_event_code, 32'h0000_092a, 8'h00);
        chk(n_rec, 32'h3);
    endtask

    // Legacy big-endian guest: code and reason swapped, drained irq unmasked
    task automatic t_legacy();
        wr(REG_CTRL, 32'h0000_0007);
        wr(REG_ACCEPT_LO, 32'h0900_0000);
        post_buf();
        ev(param_change_event_code, 32'h0000_092a, 8'h00);
        chk(got[0], 32'h0300_0000);
        chk(got[1], 32'h0403_0201);
        chk(got[3], 32'h2a09_0000);
        chk({31'h0, irq}, 32'h1);
        rd(REG_IRQ_STAT);
        chk(d & 32'h4, 32'h4);
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_features();
        t_record();
        t_lost();
        t_filter();
        t_legacy();
        stop_test();
    end

    // Whole sequence is well under 1000 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
